// >>> hdl/sac_pkg.sv
package sac_pkg;

	// timing
	localparam int CLK_NS      = 20;
	localparam int CONV_MAX_NS = 6000;
	localparam int CONV_CYC_I  = CONV_MAX_NS / CLK_NS;
	localparam int CONV_W      = 9;
	localparam logic [CONV_W-1:0] CONV_CYC = CONV_W'(CONV_CYC_I);
	// pend, push and load cycles before the strobe rises
	localparam int CONV_TAIL   = 3;
	localparam logic [CONV_W-1:0] CONV_DONE = CONV_W'(CONV_CYC_I - CONV_TAIL);
	localparam int CAL_DEFAULT = 80000;
	localparam int CAL_W       = 17;

	// control byte, held as 7 bits after the seventh rising edge
	localparam int CB_POL = 5;
	localparam int CB_CLK = 4;
	localparam int CB_MH  = 3;
	localparam int CB_ML  = 2;
	localparam logic [6:0] CB_FIRST  = 7'h01;
	localparam logic [3:0] CTRL_BITS = 4'h7;
	localparam logic [3:0] BIT_ONE   = 4'h1;
	localparam logic [3:0] MODE_KNOWN = 4'h5;

	// mode field
	localparam logic [1:0] MODE_SHORT = 2'h0;
	localparam logic [1:0] MODE_CAL   = 2'h1;
	localparam logic [1:0] MODE_DOWN  = 2'h2;
	localparam logic [1:0] MODE_LONG  = 2'h3;

	// acquisition and external conversion, in serial clock falls
	localparam logic [4:0] ACQ_SHORT = 5'h06;
	localparam logic [4:0] ACQ_LONG  = 5'h0E;
	localparam logic [4:0] EXT_SHORT = 5'h00;
	localparam logic [4:0] EXT_LONG  = 5'h08;

	// result word
	localparam int RES_W  = 14;
	localparam int WORD_W = 16;
	localparam logic [3:0] SHIFT_LAST = 4'hF;

	// reset values
	localparam logic [2:0] PORT_RST = 3'h0;
	localparam logic       POL_RST  = 1'b0;
	localparam logic       CLK_RST  = 1'b1;
	// pin idle levels: shutdown, data, select, clock
	localparam logic [3:0] SYNC_RST = 4'hA;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CTRL = 5'h02,
		ST_CONV = 5'h04,
		ST_CAL  = 5'h08,
		ST_DOWN = 5'h10
	} sac_state_t;

endpackage : sac_pkg

// >>> hdl/sac_buf_if.sv
`timescale 1ns/10ps
interface sac_buf_if;
	import sac_pkg::*;
	logic              wr_valid;
	logic              wr_ready;
	logic [WORD_W-1:0] wr_data;
	logic              rd_valid;
	logic              rd_ready;
	logic [WORD_W-1:0] rd_data;
	modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
	modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : sac_buf_if

// >>> hdl/sac_buf.sv
`timescale 1ns/10ps
module sac_buf
	import sac_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// both sides
	sac_buf_if.store b
);

	logic [WORD_W-1:0] mem [2];
	logic              wr_ptr;
	logic              rd_ptr;
	logic [1:0]        fill;
	wire               do_wr;
	wire               do_rd;

	assign b.wr_ready = (fill != 2'h2);
	assign b.rd_valid = (fill != 2'h0);
	assign b.rd_data  = mem[rd_ptr];
	assign do_wr      = b.wr_valid & b.wr_ready;
	assign do_rd      = b.rd_valid & b.rd_ready;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fill   <= 2'h0;
		end else begin
			if (do_wr)
				wr_ptr <= ~wr_ptr;
			if (do_rd)
				rd_ptr <= ~rd_ptr;
			fill <= fill + {1'b0, do_wr} - {1'b0, do_rd};
		end
	end

	always_ff @(posedge mclk) begin
		if (do_wr)
			mem[wr_ptr] <= b.wr_data;
	end

endmodule : sac_buf

// >>> hdl/sac_ctrl.sv
`timescale 1ns/10ps
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_DEFAULT
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rstn,
	// serial pins
	input  wire logic             cs_n,
	input  wire logic             sclk,
	input  wire logic             din,
	input  wire logic             shutdown_pin_n,
	output logic                  dout,
	output logic                  dout_oe,
	output logic                  conversion_strobe_out,
	output logic                  conversion_strobe_oe,
	// user outputs
	output logic                  user_out_2,
	output logic                  user_out_1,
	output logic                  user_out_0,
	// converter core
	input  wire logic [RES_W-1:0] core_code,
	output logic                  polarity_select,
	output logic                  clock_source_select,
	output logic                  acquiring,
	output logic                  calibrating,
	output logic                  powered_down,
	output logic                  cal_defaults_load
);

	sac_state_t          state;
	sac_state_t          next_state;
	logic [3:0]          s1, s2, s3, filt;
	logic                sclk_q, cs_q;
	logic [6:0]          cbyte;
	logic [3:0]          bitcnt;
	logic                armed, await_p0, long_q, down_q, pend;
	logic [4:0]          acq_cnt, ext_cnt;
	logic [CONV_W-1:0]   conv_cnt;
	logic [CAL_W-1:0]    cal_cnt;
	logic [WORD_W-1:0]   sh;
	logic [3:0]          shcnt;
	logic [2:0]          port;
	logic [WORD_W-1:0]   word;
	sac_buf_if           bq ();

	// pin synchronisers
	wire [3:0] pins = {shutdown_pin_n, din, cs_n, sclk};
	for (genvar i = 0; i < 4; i++) begin : g_sync
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				s1[i]   <= SYNC_RST[i];
				s2[i]   <= SYNC_RST[i];
				s3[i]   <= SYNC_RST[i];
				filt[i] <= SYNC_RST[i];
			end else begin
				s1[i] <= pins[i];
				s2[i] <= s1[i];
				s3[i] <= s2[i];
				if (s2[i] == s3[i])
					filt[i] <= s3[i];
			end
		end
	end

	// decode
	wire sclk_f   = filt[0];
	wire cs_f     = filt[1];
	wire din_f    = filt[2];
	wire shutdown_pin_n_f   = filt[3];
	wire rise     = sclk_f & ~sclk_q & ~cs_f;
	wire fall     = ~sclk_f & sclk_q & ~cs_f;
	wire cs_fall  = cs_q & ~cs_f;
	wire idle_lk  = (state == ST_IDLE) | (state == ST_DOWN);
	wire busy     = (state == ST_CONV) | (state == ST_CAL);
	wire start_ok = rise & din_f & ((idle_lk & ~await_p0) | (busy & armed));
	wire ctrl_done = (state == ST_CTRL) & fall & (bitcnt == CTRL_BITS);
	wire [1:0] mode = cbyte[CB_MH:CB_ML];
	wire [6:0] cb_align = cbyte << (CTRL_BITS - bitcnt);
	wire [1:0] mode_now = cb_align[CB_MH:CB_ML];
	wire new_long = (mode_now == MODE_LONG) | ((mode_now == MODE_DOWN) & long_q);
	wire acq_long = (bitcnt >= MODE_KNOWN) ? new_long : long_q;
	wire [4:0] acq_lim = acq_long ? ACQ_LONG : ACQ_SHORT;
	wire [4:0] ext_lim = long_q ? EXT_LONG : EXT_SHORT;
	wire conv_end = (state == ST_CONV) & ~pend &
		(clock_source_select ? (conv_cnt >= CONV_DONE) : (ext_cnt >= ext_lim));
	wire cal_end  = (state == ST_CAL) & (cal_cnt == CAL_W'(CAL_CYCLES));
	wire cal_stop = (state == ST_CAL) & (cal_end | ~shutdown_pin_n_f | start_ok);
	wire push     = bq.wr_valid & bq.wr_ready;
	wire load     = bq.rd_valid & bq.rd_ready;

	// result coding
	assign word = polarity_select ? {core_code, 2'h0}
		: {~core_code[RES_W-1], core_code[RES_W-2:0], 2'h0};
	assign bq.wr_valid = pend;
	assign bq.rd_ready = (shcnt == 4'h0);

	sac_buf u_buf (
		.mclk (mclk),
		.rstn (rstn),
		.b    (bq.store)
	);

	// framing sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE, ST_DOWN: begin
				if (start_ok)
					next_state = ST_CTRL;
			end
			ST_CTRL: begin
				if (ctrl_done)
					next_state = (mode == MODE_CAL) ? ST_CAL : ST_CONV;
			end
			ST_CONV: begin
				if (start_ok)
					next_state = ST_CTRL;
				else if (push)
					next_state = down_q ? ST_DOWN : ST_IDLE;
			end
			ST_CAL: begin
				if (start_ok)
					next_state = ST_CTRL;
				else if (cal_stop)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state        <= ST_IDLE;
			calibrating  <= 1'b0;
			powered_down <= 1'b0;
		end else begin
			state        <= next_state;
			calibrating  <= (next_state == ST_CAL);
			powered_down <= (next_state == ST_DOWN);
		end
	end

	// edges and control byte capture
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
			cbyte  <= 7'h00;
			bitcnt <= 4'h0;
			armed  <= 1'b0;
		end else begin
			sclk_q <= sclk_f;
			cs_q   <= cs_f;
			if (start_ok) begin
				cbyte  <= CB_FIRST;
				bitcnt <= BIT_ONE;
			end else if ((state == ST_CTRL) & rise & (bitcnt != CTRL_BITS)) begin
				cbyte  <= {cbyte[5:0], din_f};
				bitcnt <= bitcnt + BIT_ONE;
			end
			if (cs_fall)
				armed <= 1'b1;
			else if (start_ok)
				armed <= 1'b0;
		end
	end

	// configuration and user port
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			polarity_select     <= POL_RST;
			clock_source_select <= CLK_RST;
			port                <= PORT_RST;
			long_q              <= 1'b0;
			down_q              <= 1'b0;
			await_p0            <= 1'b0;
		end else begin
			if ((state == ST_CTRL) & rise & (bitcnt == BIT_ONE))
				polarity_select <= din_f;
			if (ctrl_done) begin
				clock_source_select <= cbyte[CB_CLK];
				long_q              <= new_long;
				down_q              <= (mode == MODE_DOWN);
			end
			if (start_ok)
				await_p0 <= 1'b0;
			else if (ctrl_done)
				await_p0 <= 1'b1;
			else if (rise & await_p0) begin
				port     <= {cbyte[1:0], din_f};
				await_p0 <= 1'b0;
			end
		end
	end

	assign user_out_2 = port[2];
	assign user_out_1 = port[1];
	assign user_out_0 = port[0];

	// acquisition window
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acquiring <= 1'b0;
			acq_cnt   <= 5'h00;
		end else if (start_ok) begin
			acquiring <= 1'b1;
			acq_cnt   <= 5'h00;
		end else if (acquiring & fall) begin
			acq_cnt <= acq_cnt + 5'h01;
			if (acq_cnt + 5'h01 == acq_lim)
				acquiring <= 1'b0;
		end
	end

	// conversion and calibration timing
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			conv_cnt <= '0;
			ext_cnt  <= 5'h00;
			cal_cnt  <= '0;
			pend     <= 1'b0;
		end else begin
			if (ctrl_done) begin
				conv_cnt <= '0;
				ext_cnt  <= 5'h00;
				cal_cnt  <= '0;
			end else begin
				if ((state == ST_CONV) & ~pend & clock_source_select & ~conv_end)
					conv_cnt <= conv_cnt + CONV_W'(1);
				if ((state == ST_CONV) & fall)
					ext_cnt <= ext_cnt + 5'h01;
				if (state == ST_CAL)
					cal_cnt <= cal_cnt + CAL_W'(1);
			end
			if (conv_end)
				pend <= 1'b1;
			else if (push | start_ok)
				pend <= 1'b0;
		end
	end

	// stored result, hold until the buffer takes it
	logic [WORD_W-1:0] pend_word;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			pend_word <= '0;
		else if (conv_end)
			pend_word <= word;
	end
	assign bq.wr_data = pend_word;

	// strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			conversion_strobe_out <= 1'b1;
			conversion_strobe_oe  <= 1'b1;
		end else begin
			conversion_strobe_oe <= clock_source_select | ~cs_f;
			if (ctrl_done)
				conversion_strobe_out <= (mode == MODE_CAL) & ~cbyte[CB_CLK];
			else if (cal_stop)
				conversion_strobe_out <= clock_source_select;
			else if (load)
				conversion_strobe_out <= 1'b1;
			else if (~clock_source_select & fall & (state != ST_CAL))
				conversion_strobe_out <= 1'b0;
		end
	end

	// output shifter
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sh      <= '0;
			shcnt   <= 4'h0;
			dout_oe <= 1'b0;
		end else begin
			dout_oe <= ~cs_f;
			if (load) begin
				sh    <= bq.rd_data;
				shcnt <= SHIFT_LAST;
			end else if (fall & (shcnt != 4'h0)) begin
				sh    <= {sh[WORD_W-2:0], 1'b0};
				shcnt <= shcnt - 4'h1;
			end
		end
	end
	assign dout = sh[WORD_W-1];

	// reset pulse to the calibration store
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cal_defaults_load <= 1'b1;
		else
			cal_defaults_load <= 1'b0;
	end

	// checks
	strobe_float_a: assert property (@(posedge mclk) disable iff (!rstn)
		(!clock_source_select && cs_f && $stable(clock_source_select)) |=> !conversion_strobe_oe)
		else $error("strobe driven with chip select high in external mode");

	strobe_driven_a: assert property (@(posedge mclk) disable iff (!rstn)
		(clock_source_select && $stable(clock_source_select)) |=> conversion_strobe_oe)
		else $error("strobe released in internal mode");

	sclk_ignored_a: assert property (@(posedge mclk) disable iff (!rstn)
		cs_f |=> $stable(cbyte) && $stable(acq_cnt) && $stable(ext_cnt))
		else $error("serial clock used with chip select high");

	conv_bound_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state == ST_CONV && clock_source_select) |-> conv_cnt <= CONV_DONE)
		else $error("internal conversion overran");

	start_only_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state == ST_IDLE && !rise) |=> state == ST_IDLE)
		else $error("left idle without a start bit");

	port_update_a: assert property (@(posedge mclk) disable iff (!rstn)
		(port != $past(port)) |-> $past(await_p0 && rise))
		else $error("user outputs changed outside a control byte");

	msb_shown_a: assert property (@(posedge mclk) disable iff (!rstn)
		load |=> dout == $past(bq.rd_data[WORD_W-1]) && shcnt == SHIFT_LAST)
		else $error("msb not presented on load");

	cal_strobe_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state == ST_CAL && $past(state == ST_CAL))
		|-> conversion_strobe_out == !clock_source_select)
		else $error("calibration strobe level wrong");

	coding_a: assert property (@(posedge mclk) disable iff (!rstn)
		conv_end |=> pend_word[WORD_W-1] ==
			($past(polarity_select) ? $past(core_code[RES_W-1]) : !$past(core_code[RES_W-1])))
		else $error("result coding wrong");

	cal_abort_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state == ST_CAL && !shutdown_pin_n_f) |=> state != ST_CAL)
		else $error("calibration kept running in shutdown");

endmodule : sac_ctrl

// >>> bench/sac_host.sv
`timescale 1ns/10ps
module sac_host (
	// clock
	input  wire logic mclk,
	// serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout
);
	logic din_q = 1'b0;
	logic noise = 1'b0;
	logic q;
	// released data line toggles so a stale level is never trusted
	assign din = cs_n ? noise : din_q;
	always @(posedge mclk) noise <= ~noise;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge mclk);
	endtask : half
	task automatic cs(input logic v);
		cs_n <= v;
		repeat (8) @(posedge mclk);
	endtask : cs
	// one serial clock, data out taken just before the fall
	task automatic pulse(input logic d, output logic r);
		din_q <= d;
		half();
		sclk <= 1'b1;
		half();
		r = dout;
		sclk <= 1'b0;
	endtask : pulse
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			pulse(b[i], q);
		end
		din_q <= 1'b0;
		half();
	endtask : send
	task automatic clocks(input int k);
		for (int i = 0; i < k; i++) begin
			pulse(1'b0, q);
		end
		repeat (8) @(posedge mclk);
	endtask : clocks
	task automatic read(output logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			pulse(1'b0, w[i]);
		end
		half();
	endtask : read
endmodule : sac_host

// >>> bench/test_sac_ctrl.sv
`timescale 1ns/10ps
module test_sac_ctrl
	import sac_pkg::*;
;
	localparam int CAL = 200;
	// pins and core side
	logic             mclk;
	logic             rstn;
	logic             cs_n;
	logic             sclk;
	logic             din;
	logic             shutdown_pin_n;
	logic             dout;
	logic             dout_oe;
	logic             conversion_strobe_out;
	logic             conversion_strobe_oe;
	logic [2:0]       user_out;
	logic [RES_W-1:0] core_code;
	logic             pol_sel;
	logic             clk_sel;
	logic             acquiring;
	logic             calibrating;
	logic             powered_down;
	logic             cal_load;
	// bench state
	int               failures = 0;
	int               check_count = 0;
	int               n;
	logic [31:0]      seed = 32'h00015BEA;
	logic [15:0]      w;
	logic [7:0]       b;
	logic [1:0]       modes [3] = '{MODE_SHORT, MODE_LONG, MODE_DOWN};

	sac_ctrl #(
		.CAL_CYCLES(CAL)
	) dut (
		.mclk                  (mclk),
		.rstn                  (rstn),
		.cs_n                  (cs_n),
		.sclk                  (sclk),
		.din                   (din),
		.shutdown_pin_n        (shutdown_pin_n),
		.dout                  (dout),
		.dout_oe               (dout_oe),
		.conversion_strobe_out (conversion_strobe_out),
		.conversion_strobe_oe  (conversion_strobe_oe),
		.user_out_2            (user_out[2]),
		.user_out_1            (user_out[1]),
		.user_out_0            (user_out[0]),
		.core_code             (core_code),
		.polarity_select       (pol_sel),
		.clock_source_select   (clk_sel),
		.acquiring             (acquiring),
		.calibrating           (calibrating),
		.powered_down          (powered_down),
		.cal_defaults_load     (cal_load)
	);
	sac_host host (
		.mclk (mclk),
		.cs_n (cs_n),
		.sclk (sclk),
		.din  (din),
		.dout (dout)
	);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	// result word: code, msb flipped when bipolar, two zero bits after
	function automatic logic [15:0] model(input logic uni, input logic [RES_W-1:0] c);
		int v;
		v = uni ? int'(c) : (int'(c) ^ 8192);
		return 16'(v * 4);
	endfunction : model
	task automatic results();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic wait_s(input logic v, input int lim);
		n = 0;
		while (conversion_strobe_out !== v) begin
			@(posedge mclk);
			n++;
			if (n > lim) begin
				failures++;
				$display("ERROR strobe expected %b seen %b", v, conversion_strobe_out);
				results();
			end
		end
	endtask : wait_s
	task automatic done(input string t);
		$display("test %s done", t);
	endtask : done

	initial begin
		rstn = 1'b0;
		shutdown_pin_n = 1'b1;
		core_code = '0;
		repeat (6) @(posedge mclk);
		check("port reset", 16'h0000, 16'(user_out));
		check("polarity reset", 16'h0000, 16'(pol_sel));
		check("clock reset", 16'h0001, 16'(clk_sel));
		check("cal defaults", 16'h0001, 16'(cal_load));
		rstn <= 1'b1;
		repeat (8) @(posedge mclk);
		host.cs(1'b0);
		host.send(8'h00);
		check("no start", 16'h0000, 16'(acquiring));
		done("framing");
		host.send(8'hA8);
		host.cs(1'b1);
		check("cal strobe", 16'h0000, 16'(conversion_strobe_out));
		check("calibrating", 16'h0001, 16'(calibrating));
		wait_s(1'b1, CAL + 40);
		check("cal end", 16'h0000, 16'(calibrating));
		host.cs(1'b0);
		host.send(8'h88);
		check("ext cal strobe", 16'h0001, 16'(conversion_strobe_out));
		wait_s(1'b0, CAL + 40);
		check("ext cal length", 16'h0001, 16'(n > CAL / 2));
		host.cs(1'b1);
		check("ext strobe off", 16'h0000, 16'(conversion_strobe_oe));
		host.cs(1'b0);
		host.send(8'hA8);
		shutdown_pin_n <= 1'b0;
		repeat (8) @(posedge mclk);
		check("shutdown stop", 16'h0000, 16'(calibrating));
		shutdown_pin_n <= 1'b1;
		host.send(8'hA8);
		host.cs(1'b1);
		done("calibration");
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			core_code <= seed[RES_W-1:0];
			b = {1'b1, seed[20], 1'b1, modes[i % 3], seed[26:24]};
			host.cs(1'b0);
			host.send(b);
			check("abort cal", 16'h0000, 16'(calibrating));
			check("conv strobe", 16'h0000, 16'(conversion_strobe_out));
			host.cs(1'b1);
			check("strobe held", 16'h0001, 16'(conversion_strobe_oe));
			wait_s(1'b1, 290);
			check("ports", 16'(b[2:0]), 16'(user_out));
			check("polarity", 16'(b[6]), 16'(pol_sel));
			check("power down", 16'(modes[i % 3] == MODE_DOWN), 16'(powered_down));
			host.cs(1'b0);
			host.read(w);
			check("dout drive", 16'h0001, 16'(dout_oe));
			host.cs(1'b1);
			check("result", model(b[6], core_code), w);
			check("dout off", 16'h0000, 16'(dout_oe));
		end
		done("conversion");
		host.cs(1'b0);
		host.send(8'h98);
		check("long acquire", 16'h0001, 16'(acquiring));
		host.cs(1'b1);
		host.clocks(8);
		check("ext strobe idle", 16'h0000, 16'(conversion_strobe_oe));
		host.cs(1'b0);
		check("paused acquire", 16'h0001, 16'(acquiring));
		host.clocks(5);
		check("acquire 13", 16'h0001, 16'(acquiring));
		host.clocks(1);
		check("acquire 14", 16'h0000, 16'(acquiring));
		host.clocks(24);
		host.cs(1'b1);
		host.cs(1'b0);
		host.send(8'hC7);
		check("short acquire", 16'h0000, 16'(acquiring));
		check("ext ports", 16'h0007, 16'(user_out));
		check("ext polarity", 16'h0001, 16'(pol_sel));
		host.clocks(24);
		host.cs(1'b1);
		done("external");
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		check("port again", 16'h0000, 16'(user_out));
		check("clock again", 16'h0001, 16'(clk_sel));
		check("polarity again", 16'h0000, 16'(pol_sel));
		check("cal again", 16'h0001, 16'(cal_load));
		check("strobe again", 16'h0001, 16'(conversion_strobe_out));
		rstn <= 1'b1;
		repeat (8) @(posedge mclk);
		check("cal load off", 16'h0000, 16'(cal_load));
		check("strobe drive", 16'h0001, 16'(conversion_strobe_oe));
		done("reset");
		results();
	end
endmodule : test_sac_ctrl
